// ===== include/psrst_consts.svh
// Timing and reset constants for the soft reset sequencer
`ifndef PSRST_CONSTS_SVH
`define PSRST_CONSTS_SVH
`define PSRST_CLK_PERIOD_NS 10
`define PSRST_SETTLE_NS 400
`define PSRST_SETTLE_CYC (`PSRST_SETTLE_NS / `PSRST_CLK_PERIOD_NS)
`define PSRST_PIPE_CYC 7
`define PSRST_GAP_NS 6
`define PSRST_GAP_CYC ((`PSRST_GAP_NS + `PSRST_CLK_PERIOD_NS - 1) / `PSRST_CLK_PERIOD_NS)
`define PSRST_RWR_NS 35
`define PSRST_RWR_CYC ((`PSRST_RWR_NS + `PSRST_CLK_PERIOD_NS - 1) / `PSRST_CLK_PERIOD_NS)
`define PSRST_CFG_DEFAULT 16'h8f1f
`define PSRST_ROW_START 13'h0000
`define PSRST_REFRESH_DIV 16'h0040
`endif

// ===== include/psrst_pkg.sv
// Types for the soft reset sequencer
package psrst_pkg;
  typedef enum logic [2:0] {
    PSRST_IDLE   = 3'b001,
    PSRST_ARMED  = 3'b010,
    PSRST_SETTLE = 3'b100
  } psrst_state_t;
  typedef struct packed {
    logic busy;
    logic standby;
    logic arrayInvalid;
    logic refreshOn;
  } psrst_status_t;
endpackage

// ===== src/psrst_soft_reset.sv
// Software reset sequencing for an octal serial pseudo-static DRAM
`timescale 1ns/1ps
`default_nettype none
`include "psrst_consts.svh"

module psrst_soft_reset #(
  parameter int ROW_W = 13,
  parameter int CFG_W = 16,
  parameter logic [15:0] REFRESH_DIV = `PSRST_REFRESH_DIV
) (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Transaction decode
  input wire logic resetCmd,
  input wire logic selectN,
  input wire logic cfgWrite,
  input wire logic [CFG_W-1:0] cfgWriteData,
  // Device state
  output logic [CFG_W-1:0] cfgValue,
  output logic [ROW_W-1:0] refreshRow,
  output logic refreshPulse,
  output psrst_pkg::psrst_status_t status
);
  import psrst_pkg::*;

  localparam logic [8:0] SETTLE_CYC = 9'(`PSRST_SETTLE_CYC);
  // Settle count less pin sync, state and status latency and pin phase
  localparam logic [8:0] SETTLE_LOAD = SETTLE_CYC - 9'(`PSRST_PIPE_CYC);

  // ----------------------------------------
  // Select pin synchroniser
  // ----------------------------------------
  logic [2:0] selSync_reg;
  logic selStable_reg;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      selSync_reg <= 3'h7;
    end else begin
      selSync_reg <= {selSync_reg[1:0], selectN};
    end
  end
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      selStable_reg <= 1'b1;
    end else if (selSync_reg[1] == selSync_reg[2]) begin
      selStable_reg <= selSync_reg[2];
    end
  end
  logic selRise;
  assign selRise = (selSync_reg[1] == selSync_reg[2]) && selSync_reg[2] && !selStable_reg;

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  psrst_state_t state_reg;
  logic [8:0] settleCnt_reg;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_reg <= PSRST_IDLE;
      settleCnt_reg <= 9'h000;
    end else begin
      unique case (state_reg)
        PSRST_IDLE: begin
          if (resetCmd) begin
            state_reg <= PSRST_ARMED;
          end
        end
        PSRST_ARMED: begin
          if (selRise) begin
            state_reg <= PSRST_SETTLE;
            settleCnt_reg <= SETTLE_LOAD;
          end
        end
        PSRST_SETTLE: begin
          if (settleCnt_reg == 9'h000) begin
            state_reg <= PSRST_IDLE;
          end else begin
            settleCnt_reg <= settleCnt_reg - 9'h001;
          end
        end
        default: begin
          state_reg <= PSRST_IDLE;
        end
      endcase
    end
  end
  logic inReset;
  assign inReset = (state_reg == PSRST_SETTLE);
  // A configuration write lands only while no reset is armed or settling
  function automatic logic writeOpen(input psrst_state_t s, input logic wr);
    return wr && (s == PSRST_IDLE);
  endfunction

  // ----------------------------------------
  // Configuration register
  // ----------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cfgValue <= CFG_W'(`PSRST_CFG_DEFAULT);
    end else if (inReset) begin
      cfgValue <= CFG_W'(`PSRST_CFG_DEFAULT);
    end else if (writeOpen(state_reg, cfgWrite)) begin
      cfgValue <= cfgWriteData;
    end
  end

  // ----------------------------------------
  // Self-refresh timer and row counter
  // ----------------------------------------
  logic [15:0] divCnt_reg;
  logic refreshTick;
  assign refreshTick = (divCnt_reg == 16'h0000);
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      divCnt_reg <= 16'h0000;
    end else if (inReset) begin
      divCnt_reg <= REFRESH_DIV - 16'h0001;
    end else if (refreshTick) begin
      divCnt_reg <= REFRESH_DIV - 16'h0001;
    end else begin
      divCnt_reg <= divCnt_reg - 16'h0001;
    end
  end
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      refreshRow <= ROW_W'(`PSRST_ROW_START);
      refreshPulse <= 1'b0;
    end else if (inReset) begin
      refreshRow <= ROW_W'(`PSRST_ROW_START);
      refreshPulse <= 1'b0;
    end else begin
      refreshPulse <= refreshTick;
      if (refreshTick) begin
        refreshRow <= refreshRow + ROW_W'(1);
      end
    end
  end

  // ----------------------------------------
  // Status
  // ----------------------------------------
  logic invalid_reg;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      invalid_reg <= 1'b0;
    end else if (inReset) begin
      invalid_reg <= 1'b1;
    end else if (writeOpen(state_reg, cfgWrite)) begin
      invalid_reg <= 1'b0;
    end
  end
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      status <= '{busy: 1'b0, standby: 1'b1, arrayInvalid: 1'b0, refreshOn: 1'b1};
    end else begin
      status.busy <= inReset;
      status.standby <= !inReset && !(state_reg == PSRST_SETTLE);
      status.arrayInvalid <= inReset || invalid_reg;
      status.refreshOn <= !inReset;
    end
  end

  // ----------------------------------------
  // Refresh watch
  // ----------------------------------------
  logic [15:0] sinceRefresh_reg;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sinceRefresh_reg <= 16'h0000;
    end else if (inReset || refreshPulse) begin
      sinceRefresh_reg <= 16'h0000;
    end else begin
      sinceRefresh_reg <= sinceRefresh_reg + 16'h0001;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_settle_bound: assert property (@(posedge clock) disable iff (!nrst)
    (state_reg == PSRST_ARMED && selRise) |-> ##[2:37] status.standby)
    else $error("soft reset did not finish in time");
  chk_cfg_default: assert property (@(posedge clock) disable iff (!nrst)
    inReset |=> (cfgValue == CFG_W'(`PSRST_CFG_DEFAULT)))
    else $error("config not at default after reset");
  chk_refresh_halt: assert property (@(posedge clock) disable iff (!nrst)
    inReset |=> (!refreshPulse && refreshRow == ROW_W'(`PSRST_ROW_START)))
    else $error("refresh active during reset");
  chk_refresh_resume: assert property (@(posedge clock) disable iff (!nrst)
    $fell(inReset) |-> ##[1:300] refreshPulse)
    else $error("refresh did not resume");
  chk_row_restart: assert property (@(posedge clock) disable iff (!nrst)
    $fell(inReset) |-> ##[1:300]
      (refreshPulse && refreshRow == ROW_W'(`PSRST_ROW_START) + ROW_W'(1)))
    else $error("refresh row did not restart");
  chk_status_settle: assert property (@(posedge clock) disable iff (!nrst)
    inReset |=> (status.busy && status.arrayInvalid && !status.refreshOn))
    else $error("status not showing reset in progress");
  chk_standby_back: assert property (@(posedge clock) disable iff (!nrst)
    $fell(inReset) |=> (status.standby && !status.busy))
    else $error("standby not shown after reset");
  chk_idle_standby: assert property (@(posedge clock) disable iff (!nrst)
    (state_reg != PSRST_SETTLE && $past(state_reg) != PSRST_SETTLE) |-> status.standby)
    else $error("standby lost outside reset");
  chk_refresh_gap: assert property (@(posedge clock) disable iff (!nrst)
    !inReset |-> (sinceRefresh_reg <= REFRESH_DIV))
    else $error("self-refresh stalled");
  chk_pulse_single: assert property (@(posedge clock) disable iff (!nrst)
    refreshPulse |=> !refreshPulse)
    else $error("refresh pulse longer than one cycle");
  chk_row_step: assert property (@(posedge clock) disable iff (!nrst)
    refreshPulse |-> (refreshRow == $past(refreshRow) + ROW_W'(1)))
    else $error("refresh row did not advance by one");
endmodule
`default_nettype wire

// ===== testbench/psrst_host_model.sv
// Host controller model for the soft reset sequencer
`timescale 1ns/1ps
`default_nettype none
`include "psrst_consts.svh"
module psrst_host_model (
  input wire logic clock,
  output logic resetCmd,
  output logic selectN,
  output logic cfgWrite,
  output logic [15:0] cfgWriteData
);
  initial begin
    resetCmd = 1'b0;
    selectN = 1'b1;
    cfgWrite = 1'b0;
    cfgWriteData = 16'h0000;
  end
  // Reset transaction, select released last
  task automatic softReset();
    @(negedge clock);
    selectN <= 1'b0;
    @(negedge clock);
    resetCmd <= 1'b1;
    @(negedge clock);
    resetCmd <= 1'b0;
    @(negedge clock);
    selectN <= 1'b1;
  endtask
  // Configuration write, data inverted once released
  task automatic writeCfg(input logic [15:0] d);
    @(negedge clock);
    selectN <= 1'b0;
    cfgWrite <= 1'b1;
    cfgWriteData <= d;
    @(negedge clock);
    selectN <= 1'b1;
    cfgWrite <= 1'b0;
    cfgWriteData <= ~d;
    repeat (`PSRST_GAP_CYC + `PSRST_RWR_CYC) @(negedge clock);
  endtask
endmodule
`default_nettype wire

// ===== testbench/psrst_soft_reset_bench.sv
// Self-checking bench for the soft reset sequencer
`timescale 1ns/1ps
`default_nettype none
`include "psrst_consts.svh"
module psrst_soft_reset_bench;
  import psrst_pkg::*;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  wire logic resetCmd, selectN, cfgWrite;
  wire logic [15:0] cfgWriteData;
  logic [15:0] cfgValue;
  logic [12:0] refreshRow;
  logic refreshPulse;
  psrst_status_t status;
  int n_fail = 0;
  int samples_checked = 0;
  int t;
  int pulseGap = 0;
  logic [31:0] seed = 32'h0000e828;
  logic [15:0] expQ[$];
  logic busyPrev = 1'b0;
  always #5 clock = ~clock;
  psrst_host_model host (.clock(clock), .resetCmd(resetCmd), .selectN(selectN),
    .cfgWrite(cfgWrite), .cfgWriteData(cfgWriteData));
  psrst_soft_reset uut (.clock(clock), .nrst(nrst), .resetCmd(resetCmd), .selectN(selectN),
    .cfgWrite(cfgWrite), .cfgWriteData(cfgWriteData), .cfgValue(cfgValue),
    .refreshRow(refreshRow), .refreshPulse(refreshPulse), .status(status));
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic check(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Monitor: completion of each reset against the oldest note
  always @(negedge clock) begin
    if (busyPrev === 1'b1 && status.busy === 1'b0) begin
      if (expQ.size() == 0) check(1'b0, "unexpected completion");
      else check(cfgValue === expQ.pop_front() && refreshRow === `PSRST_ROW_START,
        "state after reset");
    end
    busyPrev <= status.busy;
  end
  // Monitor: spacing of refresh pulses outside reset
  always @(negedge clock) begin
    if (nrst !== 1'b1 || status.busy !== 1'b0) begin
      pulseGap <= 0;
    end else if (refreshPulse === 1'b1) begin
      if (pulseGap != 0) check(pulseGap == `PSRST_REFRESH_DIV, "refresh period");
      pulseGap <= 1;
    end else if (pulseGap != 0) begin
      pulseGap <= pulseGap + 1;
    end
  end
  initial begin
    #50000;
    n_fail++;
    finish_test();
  end
  initial begin
    repeat (6) @(negedge clock);
    nrst = 1'b1;
    check(cfgValue === `PSRST_CFG_DEFAULT && status.standby === 1'b1, "reset state");
    for (int i = 0; i < 3; i++) begin
      seed = xorshift(seed);
      host.writeCfg(seed[15:0]);
      check(cfgValue === seed[15:0], "config write");
      repeat (200) @(negedge clock);
      check(refreshRow !== `PSRST_ROW_START, "refresh idle");
      expQ.push_back(`PSRST_CFG_DEFAULT);
      host.softReset();
      t = 0;
      while (status.busy !== 1'b1 && t < 40) begin
        @(negedge clock);
        t++;
      end
      check(status.arrayInvalid === 1'b1 && status.refreshOn === 1'b0, "settle");
      if (i == 1) begin
        host.writeCfg(seed[15:0]);
        t += 2 + `PSRST_GAP_CYC + `PSRST_RWR_CYC;
        check(cfgValue === `PSRST_CFG_DEFAULT, "write taken in settle");
      end
      while (status.busy !== 1'b0 && t < 60) begin
        @(negedge clock);
        t++;
      end
      check(t <= `PSRST_SETTLE_CYC && status.standby === 1'b1, "settle time");
      check(status.refreshOn === 1'b1, "refresh off");
      repeat (`PSRST_REFRESH_DIV + 4) @(negedge clock);
      check(refreshRow === 13'h0001, "refresh restart row");
    end
    finish_test();
  end
endmodule
`default_nettype wire
